// >>> plcs_pkg.sv
`default_nettype none
package plcs_pkg;
  // Register offsets, as byte addresses in configuration space.
  localparam logic [7:0]  LINK_CONTROL_OFS   = 8'ha0;
  localparam logic [7:0]  LINK_STATUS_OFS    = 8'ha2;
  localparam logic [15:0] LINK_CONTROL_RST   = 16'h0000;
  // Link control field positions.
  localparam int CTL_ASPM_LSB   = 0;
  localparam int CTL_RCB_BIT    = 3;
  localparam int CTL_LD_BIT     = 4;
  localparam int CTL_RL_BIT     = 5;
  localparam int CTL_CCC_BIT    = 6;
  localparam int CTL_ES_BIT     = 7;
  localparam int CTL_CPM_BIT    = 8;
  // Link status field positions and fixed values.
  localparam int STS_SPEED_LSB  = 0;
  localparam int STS_WIDTH_LSB  = 4;
  localparam int STS_SCC_BIT    = 12;
  localparam logic [3:0] LINK_SPEED_2G5   = 4'h1;
  localparam logic [5:0] NEG_WIDTH_X1     = 6'h01;
  // Reported L0s exit latency encodings.
  localparam logic [2:0] L0S_LAT_COMMON   = 3'h3;
  localparam logic [2:0] L0S_LAT_ASYNC    = 3'h4;
  // Fixed read completion boundary of this device, in bytes.
  localparam int OWN_RCB_BYTES  = 128;

  typedef enum logic [1:0] {
    PLCS_ASPM_OFF,
    PLCS_ASPM_L0S,
    PLCS_ASPM_L1,
    PLCS_ASPM_BOTH
  } plcs_aspm_e;

  // Writable state of the link control register.
  typedef struct packed {
    logic       clock_pm_enable;
    logic       ext_sync_enable;
    logic       common_clock;
    logic       read_completion_boundary;
    plcs_aspm_e aspm_control;
  } plcs_ctl_s;

  // Configuration access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } plcs_cfg_req_s;

  // Policy outputs toward the link layer.
  typedef struct packed {
    logic       l0s_entry_allowed;
    logic       l1_entry_allowed;
    logic       ext_sync;
    logic       clock_pm_allowed;
    logic [2:0] l0s_exit_latency;
    logic       common_clock;
  } plcs_policy_s;
endpackage : plcs_pkg
`default_nettype wire

// >>> plcs_link_regs.sv
`timescale 1ns/1ps
`default_nettype none
module plcs_link_regs (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire plcs_pkg::plcs_cfg_req_s cfg_req,
  input  wire logic                   slot_clock_common,
  input  wire logic                   link_idle_clock_stop,
  output logic [15:0]                 cfg_rdata,
  output logic                        cfg_ack,
  output logic                        clock_request_n,
  output plcs_pkg::plcs_policy_s      policy
);

  plcs_pkg::plcs_ctl_s ctl;
  logic [15:0]         next_rdata;
  logic                hit_ctl;
  logic                hit_sts;

  // Both registers share one aligned dword; either half may be addressed.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign hit_ctl = hit(cfg_req.addr, plcs_pkg::LINK_CONTROL_OFS);
  assign hit_sts = hit(cfg_req.addr, plcs_pkg::LINK_STATUS_OFS);

  // Only bits 8:6, 3 and 1:0 hold state; all else discards writes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= plcs_pkg::plcs_ctl_s'({plcs_pkg::LINK_CONTROL_RST[8:6],
        plcs_pkg::LINK_CONTROL_RST[3],
        plcs_pkg::LINK_CONTROL_RST[1:0]});
    end else if (cfg_req.wr && hit_ctl) begin
      if (cfg_req.be[1]) begin
        ctl.clock_pm_enable <= cfg_req.wdata[plcs_pkg::CTL_CPM_BIT];
      end
      if (cfg_req.be[0]) begin
        ctl.ext_sync_enable <= cfg_req.wdata[plcs_pkg::CTL_ES_BIT];
        ctl.common_clock    <= cfg_req.wdata[plcs_pkg::CTL_CCC_BIT];
        ctl.read_completion_boundary <=
          cfg_req.wdata[plcs_pkg::CTL_RCB_BIT];
        ctl.aspm_control <= plcs_pkg::plcs_aspm_e'(
          cfg_req.wdata[plcs_pkg::CTL_ASPM_LSB +: 2]);
      end
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (hit_ctl) begin
      next_rdata[plcs_pkg::CTL_CPM_BIT] = ctl.clock_pm_enable;
      next_rdata[plcs_pkg::CTL_ES_BIT]  = ctl.ext_sync_enable;
      next_rdata[plcs_pkg::CTL_CCC_BIT] = ctl.common_clock;
      next_rdata[plcs_pkg::CTL_RL_BIT]  = 1'b0;
      next_rdata[plcs_pkg::CTL_LD_BIT]  = 1'b0;
      next_rdata[plcs_pkg::CTL_RCB_BIT] = ctl.read_completion_boundary;
      next_rdata[plcs_pkg::CTL_ASPM_LSB +: 2] = ctl.aspm_control;
    end else if (hit_sts) begin
      // Bits 15:13, 11 and 10 stay zero from the default above.
      next_rdata[plcs_pkg::STS_SCC_BIT] = slot_clock_common;
      next_rdata[plcs_pkg::STS_WIDTH_LSB +: 6] =
        plcs_pkg::NEG_WIDTH_X1;
      next_rdata[plcs_pkg::STS_SPEED_LSB +: 4] =
        plcs_pkg::LINK_SPEED_2G5;
    end
  end

  // Reads answer one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 16'h0000;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_rdata <= cfg_req.rd ? next_rdata : 16'h0000;
      cfg_ack   <= cfg_req.rd | cfg_req.wr;
    end
  end

  // Clock request may only be released when software permits it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_request_n <= 1'b0;
    end else if (!ctl.clock_pm_enable) begin
      clock_request_n <= 1'b0;
    end else begin
      clock_request_n <= link_idle_clock_stop;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      policy <= '0;
    end else begin
      policy.l0s_entry_allowed <= ctl.aspm_control[0];
      policy.l1_entry_allowed  <= ctl.aspm_control[1];
      policy.ext_sync          <= ctl.ext_sync_enable;
      policy.clock_pm_allowed  <= ctl.clock_pm_enable;
      policy.common_clock      <= ctl.common_clock;
      policy.l0s_exit_latency  <= ctl.common_clock ?
        plcs_pkg::L0S_LAT_COMMON : plcs_pkg::L0S_LAT_ASYNC;
    end
  end

endmodule : plcs_link_regs
`default_nettype wire

// >>> plcs_link_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module plcs_mon (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire plcs_pkg::plcs_cfg_req_s cfg_req,
  input wire logic                    link_idle_clock_stop,
  input wire logic [15:0]             cfg_rdata,
  input wire logic                    cfg_ack,
  input wire logic                    clock_request_n,
  input wire plcs_pkg::plcs_policy_s  policy
);
  logic rc, rs;
  always_ff @(posedge clk) rc <= cfg_req.rd && cfg_req.addr == 8'ha0;
  always_ff @(posedge clk) rs <= cfg_req.rd && cfg_req.addr == 8'ha2;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_pulse: assert property ((cfg_req.rd || cfg_req.wr) |=> cfg_ack)
    else $error("ack");
  a_rdata_idle: assert property (!cfg_ack |-> !cfg_rdata) else $error("rd");
  a_ctl_zero: assert property (rc |-> !cfg_rdata[15:9] &&
    !cfg_rdata[5:4] && !cfg_rdata[2]) else $error("ctl zero");
  a_aspm_gate: assert property (rc |-> cfg_rdata[1:0] ==
    {policy.l1_entry_allowed, policy.l0s_entry_allowed}) else $error("aspm");
  a_sts_fixed: assert property (rs |->
    cfg_rdata[9:0] == 10'h011) else $error("status fixed");
  a_sts_zero: assert property (rs |->
    !cfg_rdata[15:13] && !cfg_rdata[11:10]) else $error("status zero");
  a_lat_sel: assert property (!$past(sys_rst) |->
    policy.l0s_exit_latency == 3'h4 - policy.common_clock) else $error("lat");
  a_clock_request_n_pm: assert property (clock_request_n |->
    policy.clock_pm_allowed) else $error("clock_request_n pm");
  a_clock_request_n_idle: assert property (clock_request_n |->
    $past(link_idle_clock_stop)) else $error("clock_request_n idle");
  c_status_read: cover property (rs);
  c_clock_request_n_high: cover property (clock_request_n);
  c_l1_allowed: cover property (policy.l1_entry_allowed);
endmodule : plcs_mon
bind plcs_link_regs plcs_mon plcs_mon_inst (.clk, .sys_rst, .cfg_req,
  .link_idle_clock_stop, .cfg_rdata, .cfg_ack, .clock_request_n, .policy);
`default_nettype wire

// >>> plcs_peer.sv
`timescale 1ns/1ps
`default_nettype none
module plcs_peer (
  input  wire logic clk,
  output var logic  link_idle_clock_stop = 1'b0
);
  // Asks for the clock to stop every other cycle, the harshest pattern.
  always @(posedge clk) link_idle_clock_stop <= ~link_idle_clock_stop;
endmodule : plcs_peer
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1, slot_clock_common = 1'b1, cfg_ack;
  logic link_idle_clock_stop, clock_request_n;
  logic [15:0]             cfg_rdata;
  plcs_pkg::plcs_cfg_req_s cfg_req = '0;
  plcs_pkg::plcs_policy_s  policy;
  int err_count = 0, checks_done = 0, cyc = 0;
  // Columns: byte enables, write data, expected readback, expected policy.
  logic [41:0] rows [4] = '{{2'h3, 16'hffff, 16'h01cb, 8'hf7},
    {2'h1, 16'h0002, 16'h0102, 8'h58}, {2'h2, 16'h0001, 16'h0002, 8'h48},
    {2'h3, 16'h0001, 16'h0001, 8'h88}};
  task automatic acc(logic w, logic [7:0] a, logic [1:0] b, logic [15:0] d);
    @(posedge clk);
    #1 cfg_req = '{!w, w, a, b, d};
    @(posedge clk);
    #1 cfg_req = '0;
  endtask : acc
  task automatic chk(logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
    if (g !== e) err_count++;
  endtask : chk
  task automatic chk_pol(plcs_pkg::plcs_policy_s g, plcs_pkg::plcs_policy_s e);
    checks_done++;
    if (g !== e) $display("BAD %0t policy got %h want %h", $time, g, e);
    if (g !== e) err_count++;
  endtask : chk_pol
  task automatic stop_test;
    $display("checks %0d bad %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 900) err_count++;
    if (cyc == 900) stop_test;
  end
  plcs_peer plcs_peer_inst (.clk, .link_idle_clock_stop);
  plcs_link_regs plcs_link_regs_inst (.clk, .sys_rst, .cfg_req,
    .slot_clock_common, .link_idle_clock_stop, .cfg_rdata, .cfg_ack,
    .clock_request_n, .policy);
  initial begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    foreach (rows[i]) begin
      acc(1'b1, 8'ha0, rows[i][41:40], rows[i][39:24]);
      acc(1'b0, 8'ha0, 2'h3, 16'h0);
      chk(cfg_rdata, rows[i][23:8]);
      chk_pol(policy, rows[i][7:0]);
    end
    $display("row tests done");
    chk({15'h0, clock_request_n}, 16'h0);
    acc(1'b1, 8'ha2, 2'h3, 16'hffff);
    for (int s = 0; s < 2; s++) begin
      slot_clock_common = s[0];
      acc(1'b0, 8'ha2, 2'h3, 16'h0);
      chk(cfg_rdata, {3'h0, s[0], 8'h01, 4'h1});
    end
    acc(1'b0, 8'hb0, 2'h3, 16'h0);
    chk(cfg_rdata, 16'h0);
    $display("register tests done");
    acc(1'b1, 8'ha0, 2'h3, 16'hffff);
    acc(1'b0, 8'ha0, 2'h3, 16'h0);
    chk(cfg_rdata, 16'h01cb);
    sys_rst = 1'b1;
    #25 sys_rst = 1'b0;
    acc(1'b0, 8'ha0, 2'h3, 16'h0);
    chk(cfg_rdata, 16'h0);
    chk_pol(policy, 8'h08);
    $display("reset test done");
    stop_test;
  end
endmodule : testbench
`default_nettype wire
